// [src/cog_timing.sv]
// complementary output timing: phase delay on rising events, blanking and dead-band on rising/falling events
// assumes rise/fall event inputs and comparator outputs are synchronous to clk_sys
//
// Implementation choices: the register addresses and the strobed register port.
module cog_timing
    import cog_timing_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    // event sources
    input  wire logic              rise_event,
    input  wire logic              fall_event,
    input  wire logic              comparator_one_output,
    input  wire logic              comparator_two_output,
    // outputs
    output out_pair_t              drive,
    output logic                   shutdown,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    nibble_pair_t     dead_band_count_q;
    nibble_pair_t     blanking_count_q;
    logic [CNT_W-1:0] phase_count_q;
    logic [7:0]       waveform_control_zero_q;
    logic [7:0]       waveform_control_one_q;
    logic [7:0]       shutdown_control_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [DATA_W-1:0] rdata_q;

    // count registers are not reset on purpose: they hold across warm resets
    always_ff @(posedge clk_sys) begin
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_DB:  dead_band_count_q <= reg_wdata;
                ADDR_BLK: blanking_count_q  <= reg_wdata;
                ADDR_PH:  phase_count_q     <= reg_wdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            waveform_control_zero_q <= ZERO8;
            waveform_control_one_q  <= ZERO8;
            shutdown_control_q      <= ZERO8;
            irq_en_q                <= '0;
        end else if (reg_write) begin
            unique case (reg_addr)
                ADDR_CON0:   waveform_control_zero_q <= reg_wdata;
                ADDR_CON1:   waveform_control_one_q  <= reg_wdata;
                ADDR_ASD:    shutdown_control_q      <= reg_wdata;
                ADDR_IRQ_EN: irq_en_q                <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_stat_q <= '0;
        end else begin
            if (reg_write && reg_addr == ADDR_IRQ_CLR) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_q <= irq_stat_q | irq_evt;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_q <= ZERO8;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_DB:       rdata_q <= dead_band_count_q;
                ADDR_BLK:      rdata_q <= blanking_count_q;
                ADDR_PH:       rdata_q <= {ZERO4, phase_count_q};
                ADDR_CON0:     rdata_q <= waveform_control_zero_q;
                ADDR_CON1:     rdata_q <= waveform_control_one_q;
                ADDR_ASD:      rdata_q <= shutdown_control_q;
                ADDR_IRQ_STAT: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
                ADDR_IRQ_EN:   rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_en_q};
                default:       rdata_q <= ZERO8;
            endcase
        end else begin
            rdata_q <= ZERO8;
        end
    end

    // unmapped and write-only words read as zero; the port never stalls the master
    assign reg_rdata = rdata_q;
    assign irq       = |(irq_stat_q & irq_en_q);

    ////////////////////////////////////////////////////////////////////////////
    // shutdown

    logic enabled;
    logic shut_now;

    assign enabled  = waveform_control_zero_q[CON0_EN_BIT];
    assign shut_now = shutdown_control_q[ASD_EN_BIT]
                    | (shutdown_control_q[ASD_C2_BIT] & ~comparator_two_output)
                    | (shutdown_control_q[ASD_C1_BIT] & ~comparator_one_output);
    // left combinational so a comparator trip clears the drive at the very next edge
    assign shutdown = shut_now;

    ////////////////////////////////////////////////////////////////////////////
    // event timing

    logic [CNT_W-1:0] phase_cnt_q;
    logic             phase_busy_q;
    logic [CNT_W-1:0] blank_fall_q;   // while nonzero falling events are ignored
    logic [CNT_W-1:0] blank_rise_q;   // while nonzero rising events are ignored
    logic [CNT_W-1:0] dead_rise_q;
    logic [CNT_W-1:0] dead_fall_q;
    logic             rise_pend_q;
    logic             fall_pend_q;
    logic             rise_ok;
    logic             fall_ok;
    logic             rise_act;
    logic             primary_q;
    logic             complement_q;

    // events are levels sampled every cycle: a held level is taken again each cycle
    assign rise_ok = enabled && rise_event && blank_rise_q == ZERO4;
    assign fall_ok = enabled && fall_event && blank_fall_q == ZERO4;

    // phase delay; a zero count passes the rising event straight on
    // a new rising event during a running delay restarts it from the full count
    assign rise_act = (rise_ok && phase_count_q == ZERO4)
                    || (phase_busy_q && phase_cnt_q == ONE4);

    always_ff @(posedge clk_sys) begin
        if (!resetn || !enabled) begin
            phase_busy_q <= 1'b0;
            phase_cnt_q  <= ZERO4;
        end else if (rise_ok && phase_count_q != ZERO4) begin
            phase_busy_q <= 1'b1;
            phase_cnt_q  <= phase_count_q;
        end else if (phase_busy_q) begin
            phase_cnt_q  <= phase_cnt_q - ONE4;
            phase_busy_q <= (phase_cnt_q != ONE4);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn || !enabled) begin
            blank_fall_q <= ZERO4;
            blank_rise_q <= ZERO4;
        end else begin
            if (rise_act) begin
                blank_fall_q <= blanking_count_q.rise;
            end else if (blank_fall_q != ZERO4) begin
                blank_fall_q <= blank_fall_q - ONE4;
            end
            if (fall_ok) begin
                blank_rise_q <= blanking_count_q.fall;
            end else if (blank_rise_q != ZERO4) begin
                blank_rise_q <= blank_rise_q - ONE4;
            end
        end
    end

    // a rising event drops the complement at once and raises the primary after dead band
    // it also cancels a pending complement edge, which keeps the two switches apart
    always_ff @(posedge clk_sys) begin
        if (!resetn || !enabled || shut_now) begin
            primary_q    <= 1'b0;
            complement_q <= 1'b0;
            rise_pend_q  <= 1'b0;
            fall_pend_q  <= 1'b0;
            dead_rise_q  <= ZERO4;
            dead_fall_q  <= ZERO4;
        end else if (rise_act) begin
            complement_q <= 1'b0;
            fall_pend_q  <= 1'b0;
            if (dead_band_count_q.rise == ZERO4) begin
                primary_q   <= 1'b1;
                rise_pend_q <= 1'b0;
            end else begin
                rise_pend_q <= 1'b1;
                dead_rise_q <= dead_band_count_q.rise;
            end
        end else if (fall_ok) begin
            primary_q   <= 1'b0;
            rise_pend_q <= 1'b0;
            if (dead_band_count_q.fall == ZERO4) begin
                complement_q <= 1'b1;
                fall_pend_q  <= 1'b0;
            end else begin
                fall_pend_q <= 1'b1;
                dead_fall_q <= dead_band_count_q.fall;
            end
        end else begin
            if (rise_pend_q) begin
                dead_rise_q <= dead_rise_q - ONE4;
                if (dead_rise_q == ONE4) begin
                    rise_pend_q <= 1'b0;
                    primary_q   <= 1'b1;
                end
            end
            if (fall_pend_q) begin
                dead_fall_q <= dead_fall_q - ONE4;
                if (dead_fall_q == ONE4) begin
                    fall_pend_q  <= 1'b0;
                    complement_q <= 1'b1;
                end
            end
        end
    end

    assign drive.primary    = primary_q;
    assign drive.complement = complement_q;

    always_comb begin
        irq_evt               = '0;
        irq_evt[IRQ_RISE_BIT] = rise_act;
        irq_evt[IRQ_FALL_BIT] = fall_ok;
        irq_evt[IRQ_SHUT_BIT] = enabled && shut_now;
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    AST_PH_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_read |=> reg_rdata[DATA_W-1:HI_LSB] == ZERO4 || $past(reg_addr) != ADDR_PH)
        else $error("phase upper nibble not zero");

    AST_SHUT_C2: assert property (@(posedge clk_sys) disable iff (!resetn)
        shutdown_control_q[ASD_C2_BIT] && !comparator_two_output |=> !primary_q && !complement_q)
        else $error("comparator two shutdown ignored");

    AST_SHUT_C1: assert property (@(posedge clk_sys) disable iff (!resetn)
        shutdown_control_q[ASD_C1_BIT] && !comparator_one_output |=> !primary_q && !complement_q)
        else $error("comparator one shutdown ignored");

    AST_NO_OVERLAP: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(primary_q && complement_q))
        else $error("both outputs high");

    AST_RISE_DEAD: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_act && dead_band_count_q.rise != ZERO4 |=> !$rose(primary_q))
        else $error("primary rose inside dead band");

    AST_FALL_DEAD: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall_ok && dead_band_count_q.fall != ZERO4 |=> !$rose(complement_q))
        else $error("complement rose inside dead band");

    AST_RISE_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_act && dead_band_count_q.rise == ZERO4 && enabled && !shut_now |=> primary_q)
        else $error("zero dead band delayed primary");

    AST_BLANK_FALL: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_act && blanking_count_q.rise != ZERO4 |=> !fall_ok)
        else $error("falling event not blanked");

    AST_BLANK_RISE: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall_ok && blanking_count_q.fall != ZERO4 |=> !rise_ok)
        else $error("rising event not blanked");

    AST_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_ok && phase_count_q != ZERO4 && !phase_busy_q
        |-> !rise_act ##1 (phase_busy_q && phase_cnt_q == $past(phase_count_q)))
        else $error("phase delay skipped");

    // helper for the phase check: counts up from the arming edge, apart from the
    // phase counter, so an off-by-one in the countdown shows up
    logic [CNT_W-1:0] ph_seen_q;
    logic [CNT_W-1:0] ph_want_q;
    logic             ph_armed_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn || !enabled) begin
            ph_armed_q <= 1'b0;
            ph_seen_q  <= ZERO4;
            ph_want_q  <= ZERO4;
        end else if (rise_ok && phase_count_q != ZERO4) begin
            ph_armed_q <= 1'b1;
            ph_seen_q  <= ONE4;
            ph_want_q  <= phase_count_q;
        end else if (ph_armed_q) begin
            ph_armed_q <= (ph_seen_q != ph_want_q);
            ph_seen_q  <= ph_seen_q + ONE4;
        end
    end

    AST_PHASE_COUNT: assert property (@(posedge clk_sys) disable iff (!resetn)
        ph_armed_q && !(rise_ok && phase_count_q == ZERO4)
        |-> rise_act == (ph_seen_q == ph_want_q))
        else $error("phase delay length wrong");

    AST_PRIM_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(primary_q) |-> $past(rise_act && dead_band_count_q.rise == ZERO4)
            || $past(rise_pend_q && dead_rise_q == ONE4))
        else $error("primary rose before its dead band ran out");

    AST_COMP_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(complement_q) |-> $past(fall_ok && !rise_act && dead_band_count_q.fall == ZERO4)
            || $past(fall_pend_q && dead_fall_q == ONE4))
        else $error("complement rose before its dead band ran out");

    AST_RISE_DROPS_COMP: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_act |=> !complement_q)
        else $error("complement kept after rising event");

    AST_FALL_DROPS_PRIM: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall_ok && !rise_act |=> !primary_q)
        else $error("primary kept after falling event");

    AST_FALL_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall_ok && !rise_act && dead_band_count_q.fall == ZERO4 && !shut_now |=> complement_q)
        else $error("zero dead band delayed complement");

    AST_BLANK_ZERO_R: assert property (@(posedge clk_sys) disable iff (!resetn)
        rise_act && blanking_count_q.rise == ZERO4 |=> blank_fall_q == ZERO4)
        else $error("zero rising blank opened a window");

    AST_BLANK_ZERO_F: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall_ok && blanking_count_q.fall == ZERO4 |=> blank_rise_q == ZERO4)
        else $error("zero falling blank opened a window");

endmodule : cog_timing

// [src/cog_timing_pkg.sv]
// package for the complementary output timing block: register map, fields, timing constants
// assumes a plain register port with byte-wide data in the low bits of an 8-bit word
package cog_timing_pkg;

    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam int          CNT_W         = 4;

    // register map (word index on the plain port)
    localparam logic [3:0]  ADDR_DB       = 4'h0;
    localparam logic [3:0]  ADDR_BLK      = 4'h1;
    localparam logic [3:0]  ADDR_PH       = 4'h2;
    localparam logic [3:0]  ADDR_CON0     = 4'h3;
    localparam logic [3:0]  ADDR_CON1     = 4'h4;
    localparam logic [3:0]  ADDR_ASD      = 4'h5;
    localparam logic [3:0]  ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0]  ADDR_IRQ_EN   = 4'h7;
    localparam logic [3:0]  ADDR_IRQ_CLR  = 4'h8;

    // field positions
    localparam int          HI_LSB        = 4;
    localparam int          LO_LSB        = 0;
    localparam int          CON0_EN_BIT   = 7;
    localparam int          ASD_EN_BIT    = 7;
    localparam int          ASD_C2_BIT    = 2;
    localparam int          ASD_C1_BIT    = 1;

    // interrupt status layout
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_RISE_BIT  = 0;
    localparam int          IRQ_FALL_BIT  = 1;
    localparam int          IRQ_SHUT_BIT  = 2;

    localparam logic [7:0]  ZERO8         = 8'h00;
    localparam logic [3:0]  ZERO4         = 4'h0;
    localparam logic [3:0]  ONE4          = 4'h1;

    typedef struct packed {
        logic [CNT_W-1:0] rise;
        logic [CNT_W-1:0] fall;
    } nibble_pair_t;

    typedef struct packed {
        logic primary;
        logic complement;
    } out_pair_t;

endpackage : cog_timing_pkg

// [tb/gate_driver_model.sv]
// gate driver pair on the primary and complementary outputs
// assumes drive is registered on clk_sys; flags any cycle with both switches on
module gate_driver_model
    import cog_timing_pkg::*;
(
    // clock
    input  wire logic      clk_sys,
    // gate inputs
    input  wire out_pair_t drive,
    // status to the bench
    output logic           overlap_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // both switches on at once would short the supply rail
    initial begin
        overlap_seen = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (drive.primary === 1'b1 && drive.complement === 1'b1) begin
                overlap_seen <= 1'b1;
            end
        end
    end
endmodule : gate_driver_model

// [tb/testbench.sv]
// self-checking bench for the complementary output timing block
// assumes the register map and field layout of cog_timing_pkg
module testbench
    import cog_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_sys, resetn, reg_write, reg_read, irq, shutdown, overlap_seen;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic              rise_event, fall_event, comp_one, comp_two;
    out_pair_t         drive;
    int                err_total, checks, n;
    logic [3:0]        tph[4] = '{4'h0, 4'h0, 4'h2, 4'hf};
    logic [3:0]        tdr[4] = '{4'h0, 4'h3, 4'hf, 4'h1};
    logic [3:0]        tdf[4] = '{4'h0, 4'hf, 4'h1, 4'h0};

    cog_timing i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rise_event(rise_event), .fall_event(fall_event),
        .comparator_one_output(comp_one), .comparator_two_output(comp_two),
        .drive(drive), .shutdown(shutdown), .irq(irq));
    gate_driver_model i_load (.clk_sys(clk_sys), .drive(drive), .overlap_seen(overlap_seen));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // returns just after the edge that takes the event
    task automatic pulse(input bit rise);
        @(posedge clk_sys);
        if (rise) rise_event <= 1'b1;
        else fall_event <= 1'b1;
        @(posedge clk_sys);
        rise_event <= 1'b0;
        fall_event <= 1'b0;
    endtask : pulse

    // counts edges after the taking edge until the output reaches lvl
    task automatic edges(input bit prim, input logic lvl, output int k);
        k = 0;
        #1;
        while (((prim ? drive.primary : drive.complement) !== lvl) && k < 40) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k == 40) begin
            err_total++;
            $display("wait limit hit on output");
            tally_and_finish();
        end
    endtask : edges

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, reg_write, reg_read, rise_event, fall_event} = '0;
        {reg_addr, reg_wdata} = '0;
        {comp_one, comp_two} = 2'b11;
        err_total = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        wr(ADDR_IRQ_EN, 8'h00);
        wr(ADDR_IRQ_CLR, 8'h07);
        // count registers survive a warm reset
        wr(ADDR_DB, 8'h5a);
        wr(ADDR_BLK, 8'hc3);
        wr(ADDR_PH, 8'hf7);
        wr(4'hf, 8'hff);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(ADDR_DB, d);    check("dead_band_count", 8'h5a, d);
        rd(ADDR_BLK, d);   check("blanking_count", 8'hc3, d);
        rd(ADDR_PH, d);    check("phase_delay_count", 8'h07, d);
        @(posedge clk_sys);
        #1 check("rdata idle", 8'h00, reg_rdata);
        rd(4'hf, d);       check("unmapped", 8'h00, d);
        rd(ADDR_IRQ_CLR, d); check("clear reads zero", 8'h00, d);
        wr(ADDR_CON1, 8'ha5);
        rd(ADDR_CON1, d);  check("waveform_control_one", 8'ha5, d);
        wr(ADDR_CON0, 8'h80);
        wr(ADDR_ASD, 8'h00);
        wr(ADDR_BLK, 8'h00);
        // dead-band and phase across zero, mid and full counts
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DB, {tdr[i], tdf[i]});
            wr(ADDR_PH, {4'h0, tph[i]});
            pulse(1'b1);
            edges(1'b1, 1'b1, n);
            check("rise delay", {4'h0, tph[i]} + {4'h0, tdr[i]}, n[7:0]);
            pulse(1'b0);
            edges(1'b1, 1'b0, n); check("primary off", 8'h00, n[7:0]);
            edges(1'b0, 1'b1, n); check("fall delay", {4'h0, tdf[i]}, n[7:0]);
        end
        // falling event inside the rising blank window is dropped
        wr(ADDR_PH, 8'h00);
        wr(ADDR_DB, 8'h00);
        wr(ADDR_BLK, 8'h40);
        pulse(1'b1);
        edges(1'b1, 1'b1, n);
        pulse(1'b0);
        repeat (2) @(posedge clk_sys);
        #1 check("blanked fall", 8'h01, {7'h00, drive.primary});
        repeat (2) @(posedge clk_sys);
        pulse(1'b0);
        edges(1'b1, 1'b0, n); check("fall after blank", 8'h00, n[7:0]);
        // masked status keeps irq low until enabled
        rd(ADDR_IRQ_STAT, d); check("irq status events", 8'h03, d);
        check("irq masked", 8'h00, {7'h00, irq});
        wr(ADDR_IRQ_EN, 8'h01);
        @(posedge clk_sys);
        #1 check("irq enabled", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_CLR, 8'h01);
        @(posedge clk_sys);
        #1 check("irq cleared", 8'h00, {7'h00, irq});
        // rising event inside the falling blank window is dropped
        wr(ADDR_BLK, 8'h04);
        pulse(1'b0);
        pulse(1'b1);
        repeat (3) @(posedge clk_sys);
        #1 check("blanked rise", 8'h00, {7'h00, drive.primary});
        // each comparator source forces shutdown while low
        wr(ADDR_BLK, 8'h00);
        wr(ADDR_IRQ_EN, 8'h04);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_ASD, k ? 8'h04 : 8'h02);
            pulse(1'b1);
            edges(1'b1, 1'b1, n);
            check("no shutdown", 8'h00, {7'h00, shutdown});
            @(posedge clk_sys);
            if (k) comp_two <= 1'b0;
            else comp_one <= 1'b0;
            @(posedge clk_sys);
            #1 check("shutdown", 8'h01, {7'h00, shutdown});
            check("drive off", 8'h00, {6'h00, drive});
            check("irq shutdown", 8'h01, {7'h00, irq});
            pulse(1'b1);
            #1 check("refused rise", 8'h00, {6'h00, drive});
            rd(ADDR_IRQ_STAT, d); check("irq status", 8'h04, d & 8'h04);
            @(posedge clk_sys);
            {comp_one, comp_two} <= 2'b11;
            wr(ADDR_IRQ_CLR, 8'h04);
            @(posedge clk_sys);
            #1 check("irq after clear", 8'h00, {7'h00, irq});
        end
        // the force bit shuts down with no comparator involved
        pulse(1'b1);
        edges(1'b1, 1'b1, n);
        wr(ADDR_ASD, 8'h80);
        @(posedge clk_sys);
        #1 check("forced shutdown", 8'h01, {7'h00, shutdown});
        check("forced drive off", 8'h00, {6'h00, drive});
        wr(ADDR_ASD, 8'h00);
        check("gate overlap", 8'h00, {7'h00, overlap_seen});
        tally_and_finish();
    end
endmodule : testbench
